//--- dv/tb_adc_conversion_control.sv
// Purpose: self-checking bench for the converter control block
// Assumes: wishbone classic master, comparator decision held steady per conversion except in the msb-first check, which changes it mid conversion
// Notes:   oscillator ticks arrive every other clock, so its period is 8 clocks
`timescale 1ns/10ps
module tb_adc_conversion_control;
    import adc_pkg::*;

    logic        clk, rstn, cyc, stb, we, sleep, wake, tick, dec, c1en;
    logic [3:0]  adr, sel;
    logic [31:0] wdat, wb_dat;
    logic        ack, conv_on, sampling, converting;
    logic [2:0]  apin;
    logic [1:0]  chan;
    logic [31:0] rd;
    logic [7:0]  part;
    int          error_cnt, tests_run, n;
    // clocks per conversion period for each select code
    int          div_tab [4] = '{16, 8, 4, 8};
    logic [2:0]  pin_map [4] = '{3'h0, 3'h4, 3'h5, 3'h7};

    adc_conversion_control adc_conversion_control_inst (
        .I_MCLK(clk), .I_RSTN(rstn), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we),
        .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_DAT(wb_dat),
        .O_WB_ACK(ack), .I_SLEEP(sleep), .I_WAKE(wake), .I_INTERNAL_OSCILLATOR_TICK(tick),
        .I_COMP_DECISION(dec), .I_C1_OUT_EN(c1en), .O_ANALOG_PIN(apin),
        .O_CHANNEL(chan), .O_CONVERTER_ON(conv_on), .O_SAMPLING(sampling),
        .O_CONVERTING(converting)
    );

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk) begin
        tick <= ~tick;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", what, exp, got);
            error_cnt++;
        end
    endtask

    task automatic chk_range(input string what, input int lo, input int hi, input int got);
        tests_run++;
        if (got < lo || got > hi) begin
            $display("BAD %s expected %0d..%0d seen %0d", what, lo, hi, got);
            error_cnt++;
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // one classic cycle; the request stands until ack is sampled high
    task automatic wb_cycle(input logic w, input logic [3:0] a, input logic [7:0] d);
        int k;
        @(posedge clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= 4'hF; wdat <= {24'h000000, d};
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (ack !== 1'b1 && k < 20);
        if (k >= 20) chk("ack", 1, 0);
        rd = wb_dat;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask

    task automatic wait_sig(input logic lvl, input bit samp);
        int k;
        k = 0;
        while ((samp ? sampling : converting) !== lvl && k < 2000) begin
            @(posedge clk);
            k++;
        end
        chk("level wait", 1'b1, k < 2000);
    endtask

    task automatic wait_conv();
        wait_sig(1'b1, 0);
        n = 0;
        while (converting === 1'b1 && n < 2000) begin
            @(posedge clk);
            n++;
        end
        chk("conversion end", 1'b1, n < 2000);
    endtask

    task automatic pulse(input bit w);
        @(posedge clk);
        if (w) wake <= 1'b1;
        else sleep <= 1'b1;
        @(posedge clk);
        wake <= 1'b0;
        sleep <= 1'b0;
    endtask

    task automatic t_reset();
        wb_cycle(0, ADDR_CONTROL, 8'h00);
        chk("control reset", 32'h000000FC, rd);
        chk("analog pins", 3'h7, apin);
        chk("channel", 2'h3, chan);
        chk("power", 1'b0, conv_on);
    endtask

    task automatic t_refused();
        wb_cycle(1, ADDR_CONTROL, 8'hFE);
        repeat (3) @(posedge clk);
        chk("busy while disabled", 1'b0, converting);
        wb_cycle(0, ADDR_CONTROL, 8'h00);
        chk("go refused", 32'h000000FC, rd);
        chk("power off", 1'b0, conv_on);
        wb_cycle(1, 4'hC, 8'h00);
        wb_cycle(0, 4'h8, 8'h00);
        chk("unmapped read", 32'h00000000, rd);
        wb_cycle(1, ADDR_RESULT, 8'h5A);
        wb_cycle(0, ADDR_RESULT, 8'h00);
        chk("result write", 32'h0000005A, rd);
    endtask

    task automatic t_pins();
        for (int c = 0; c < 2; c++) begin
            for (int p = 0; p < 4; p++) begin
                c1en <= c[0];
                wb_cycle(1, ADDR_CONTROL, {p[1:0], 2'h0, p[1:0], 2'h0});
                repeat (3) @(posedge clk);
                chk("analog pins", pin_map[p] & {~c[0], 2'h3}, apin);
                chk("channel idle", p[1:0], chan);
            end
        end
        c1en <= 1'b0;
    endtask

    task automatic t_timing();
        dec <= 1'b1;
        for (int s = 0; s < 4; s++) begin
            wb_cycle(1, ADDR_CONTROL, {2'h3, s[1:0], 2'h0, 2'h3});
            wait_conv();
            chk_range("periods", 13 * div_tab[s] - 4, 13 * div_tab[s] + 4, n);
            chk("power on", 1'b1, conv_on);
            wb_cycle(0, ADDR_CONTROL, 8'h00);
            chk("done clears go", {26'h0000003, s[1:0], 4'h1}, rd);
            wb_cycle(0, ADDR_RESULT, 8'h00);
            chk("full result", 32'h000000FF, rd);
        end
    endtask

    task automatic t_sample_hold();
        dec <= 1'b0;
        wb_cycle(1, ADDR_CONTROL, 8'hC3);
        wait_sig(1'b1, 1);
        wb_cycle(0, ADDR_RESULT, 8'h00);
        chk("held in sampling", 32'h000000FF, rd);
        wait_sig(1'b0, 1);
        wb_cycle(0, ADDR_RESULT, 8'h00);
        chk("cleared after sampling", 32'h00000000, rd);
        // msb decided low, every later bit high, so a reversed order shows
        repeat (35) @(posedge clk);
        dec <= 1'b1;
        wait_conv();
        wb_cycle(0, ADDR_RESULT, 8'h00);
        chk("msb first", 32'h0000007F, rd);
    endtask

    task automatic t_midchange();
        dec <= 1'b1;
        wb_cycle(1, ADDR_CONTROL, 8'hE3);
        wb_cycle(1, ADDR_CONTROL, 8'hC7);
        chk("channel frozen", 2'h0, chan);
        wait_conv();
        chk_range("old divisor kept", 44, 56, n);
        repeat (2) @(posedge clk);
        chk("channel after done", 2'h1, chan);
    endtask

    task automatic t_abort();
        wb_cycle(1, ADDR_CONTROL, 8'hC3);
        wait_sig(1'b1, 1);
        wait_sig(1'b0, 1);
        repeat (40) @(posedge clk);
        wb_cycle(1, ADDR_CONTROL, 8'h01);
        repeat (2) @(posedge clk);
        chk("stopped", 1'b0, converting);
        chk("sampling stopped", 1'b0, sampling);
        wb_cycle(0, ADDR_RESULT, 8'h00);
        part = rd[7:0];
        // ones from the top down to the marker, nothing below it
        chk("partial form", 1'b1, (~part & (~part + 8'h01)) == 8'h00 && part != 8'h00
            && part != 8'hFF);
        repeat (50) @(posedge clk);
        wb_cycle(0, ADDR_RESULT, 8'h00);
        chk("partial kept", {24'h000000, part}, rd);
        wb_cycle(0, ADDR_CONTROL, 8'h00);
        chk("go after abort", 32'h00000001, rd);
    endtask

    task automatic t_sleep();
        wb_cycle(1, ADDR_CONTROL, 8'h43);
        repeat (5) @(posedge clk);
        pulse(0);
        repeat (2) @(posedge clk);
        chk("sleep stops", 1'b0, converting);
        wb_cycle(0, ADDR_CONTROL, 8'h00);
        chk("sleep control", 32'h0000007C, rd);
        chk("pins kept", 3'h4, apin);
        pulse(1);
        wb_cycle(0, ADDR_CONTROL, 8'h00);
        chk("wake control", 32'h000000FC, rd);
        repeat (2) @(posedge clk);
        chk("wake pins", 3'h7, apin);
    endtask

    initial begin
        error_cnt = 0;
        tests_run = 0;
        rstn = 1'b0;
        {cyc, stb, we, sleep, wake, tick, dec, c1en} = 8'h00;
        adr = 4'h0;
        sel = 4'h0;
        wdat = 32'h00000000;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        t_reset();
        t_refused();
        t_pins();
        t_timing();
        t_sample_hold();
        t_midchange();
        t_abort();
        t_sleep();
        report_and_stop();
    end

    initial begin
        #400000;
        error_cnt++;
        report_and_stop();
    end

endmodule // tb_adc_conversion_control

//--- logic/adc_clock_divider.sv
// Purpose: conversion clock period generator, one tick per period
// Assumes: i_internal_oscillator_tick is a one-cycle enable from the internal oscillator
// Notes:   restart realigns the period so every conversion starts clean
`timescale 1ns/10ps
module adc_clock_divider
    import adc_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_rstn,
    input  wire logic       i_restart,
    input  wire logic [1:0] i_sel,
    input  wire logic       i_internal_oscillator_tick,
    output logic            o_tick
);
    logic [3:0] count;
    logic [3:0] last;
    logic       step;

    always_comb begin
        unique case (i_sel)
            CLK_SEL_DIV16: last = LAST_DIV16;
            CLK_SEL_DIV8:  last = LAST_DIV8;
            default:       last = LAST_DIV4;
        endcase
        step = (i_sel == CLK_SEL_INTERNAL_OSCILLATOR) ? i_internal_oscillator_tick : 1'b1;
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            count  <= 4'h0;
            o_tick <= 1'b0;
        end else if (i_restart) begin
            count  <= 4'h0;
            o_tick <= 1'b0;
        end else if (step && count == last) begin
            count  <= 4'h0;
            o_tick <= 1'b1;
        end else begin
            count  <= step ? count + 4'h1 : count;
            o_tick <= 1'b0;
        end
    end
endmodule // adc_clock_divider

//--- logic/adc_conversion_control.sv
// Purpose: control and sequencing of an 8-bit successive-approximation converter
// Assumes: wishbone classic slave, comparator decision valid at each period tick
// Notes:   analog front end is outside; this block only steers and sequences
//
// Implementation choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module adc_conversion_control
    import adc_pkg::*;
(
    input  wire logic        I_MCLK,
    input  wire logic        I_RSTN,
    input  wire logic        I_WB_CYC,
    input  wire logic        I_WB_STB,
    input  wire logic        I_WB_WE,
    input  wire logic [3:0]  I_WB_ADR,
    input  wire logic [3:0]  I_WB_SEL,
    input  wire logic [31:0] I_WB_DAT,
    output logic      [31:0] O_WB_DAT,
    output logic             O_WB_ACK,
    input  wire logic        I_SLEEP,
    input  wire logic        I_WAKE,
    input  wire logic        I_INTERNAL_OSCILLATOR_TICK,
    input  wire logic        I_COMP_DECISION,
    input  wire logic        I_C1_OUT_EN,
    output logic      [2:0]  O_ANALOG_PIN,
    output logic      [1:0]  O_CHANNEL,
    output logic             O_CONVERTER_ON,
    output logic             O_SAMPLING,
    output logic             O_CONVERTING
);
    import adc_pkg::*;

    ctrl_t       ctrl;
    ctrl_t       wdata;
    conv_state_t state;
    logic [1:0]  active_clk_sel;
    logic [3:0]  tad_cnt;
    logic [3:0]  shift_cnt;
    logic        tad_tick;
    logic [7:0]  result;
    logic [7:0]  marker;
    logic        access;
    logic        wr_ctrl;
    logic        wr_result;
    logic        start;
    logic        abort;
    logic        sample_end;
    logic        shift_now;
    logic        done;
    logic        busy;
    logic [2:0]  next_analog_pin;

    // bus decode, one access per request
    assign access    = I_WB_CYC && I_WB_STB && !O_WB_ACK;
    assign wr_ctrl   = access && I_WB_WE && I_WB_SEL[0] && I_WB_ADR == ADDR_CONTROL;
    assign wr_result = access && I_WB_WE && I_WB_SEL[0] && I_WB_ADR == ADDR_RESULT;
    assign wdata     = ctrl_t'(I_WB_DAT[7:0]);
    assign busy      = state != ST_IDLE;

    assign start      = wr_ctrl && wdata.go && wdata.converter_enable && (!busy || done)
                        && !I_SLEEP && !I_WAKE;
    assign abort      = busy && !done
                        && (I_SLEEP || I_WAKE || (wr_ctrl && (!wdata.go || !wdata.converter_enable)));
    // 13 periods split as 3 sampling, 9 shifts, 1 finish
    assign sample_end = state == ST_SAMPLE && tad_tick && tad_cnt == SAMPLE_PERIODS - 4'h1;
    assign shift_now  = state == ST_CONVERT && tad_tick && tad_cnt < CONV_PERIODS - 4'h1;
    assign done       = state == ST_CONVERT && tad_tick && tad_cnt == CONV_PERIODS - 4'h1;

    always_ff @(posedge I_MCLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            O_WB_ACK <= 1'b0;
            O_WB_DAT <= 32'h0000_0000;
        end else begin
            O_WB_ACK <= access;
            if (access && !I_WB_WE) begin
                unique case (I_WB_ADR)
                    ADDR_CONTROL: O_WB_DAT <= {24'h00_0000, ctrl};
                    ADDR_RESULT:  O_WB_DAT <= {24'h00_0000, result};
                    default:      O_WB_DAT <= 32'h0000_0000;
                endcase
            end
        end
    end

    // control register: wake beats sleep beats software beats hardware
    always_ff @(posedge I_MCLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            ctrl <= CTRL_RESET;
        end else if (I_WAKE) begin
            // wake sets fields, clears go, enable
            ctrl <= CTRL_RESET;
        end else if (I_SLEEP) begin
            ctrl.conv_clock_select <= CLK_SEL_RESET;
            ctrl.channel_select    <= CHAN_SEL_RESET;
            ctrl.go                <= 1'b0;
            ctrl.converter_enable  <= 1'b0;
        end else if (wr_ctrl) begin
            ctrl    <= wdata;
            ctrl.go <= wdata.go && wdata.converter_enable;
        end else if (done) begin
            ctrl.go <= 1'b0;
        end
    end

    // sequencer
    always_ff @(posedge I_MCLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            state <= ST_IDLE;
        end else if (start) begin
            state <= ST_SAMPLE;
        end else if (abort || done) begin
            state <= ST_IDLE;
        end else if (sample_end) begin
            state <= ST_CONVERT;
        end
    end

    // period counter, restarted with every conversion
    always_ff @(posedge I_MCLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            tad_cnt <= 4'h0;
        end else if (start) begin
            tad_cnt <= 4'h0;
        end else if (busy && tad_tick) begin
            tad_cnt <= tad_cnt + 4'h1;
        end
    end

    // clock source latched at start only
    always_ff @(posedge I_MCLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            active_clk_sel <= CLK_SEL_RESET;
        end else if (start) begin
            active_clk_sel <= wdata.conv_clock_select;
        end
    end

    always_ff @(posedge I_MCLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            O_CHANNEL <= CHAN_SEL_RESET;
        end else if (start) begin
            O_CHANNEL <= wdata.channel_select;
        end else if (!busy || abort || done) begin
            O_CHANNEL <= I_SLEEP || I_WAKE ? CHAN_SEL_RESET : ctrl.channel_select;
        end
    end

    // pin mode follows select regardless of converter enable, except I_C1_OUT_EN forces pin 2 digital
    always_comb begin
        unique case (ctrl.analog_pin_select)
            PINS_NONE:    next_analog_pin = 3'b000;
            PINS_IN2:     next_analog_pin = 3'b100;
            PINS_IN2_IN0: next_analog_pin = 3'b101;
            default:      next_analog_pin = 3'b111;
        endcase
        if (I_C1_OUT_EN) begin
            next_analog_pin[2] = 1'b0;
        end
    end

    always_ff @(posedge I_MCLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            O_ANALOG_PIN   <= 3'b111;
            O_CONVERTER_ON <= 1'b0;
            O_SAMPLING     <= 1'b0;
            O_CONVERTING   <= 1'b0;
        end else begin
            O_ANALOG_PIN   <= next_analog_pin;
            O_CONVERTER_ON <= ctrl.converter_enable;
            O_SAMPLING     <= state == ST_SAMPLE;
            O_CONVERTING   <= busy;
        end
    end

    // helper count of shifts, read by the checks below
    always_ff @(posedge I_MCLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            shift_cnt <= 4'h0;
        end else if (sample_end) begin
            shift_cnt <= 4'h0;
        end else if (shift_now) begin
            shift_cnt <= shift_cnt + 4'h1;
        end
    end

    adc_clock_divider u_divider (
        .i_clk         (I_MCLK),
        .i_rstn        (I_RSTN),
        .i_restart     (start),
        .i_sel         (active_clk_sel),
        .i_internal_oscillator_tick (I_INTERNAL_OSCILLATOR_TICK),
        .o_tick        (tad_tick)
    );

    adc_result_shifter u_result (
        .i_clk       (I_MCLK),
        .i_rstn      (I_RSTN),
        .i_clear     (sample_end && !abort),
        .i_shift     (shift_now && !abort),
        .i_bit       (I_COMP_DECISION),
        .i_load      (wr_result && !busy),
        .i_load_data (I_WB_DAT[7:0]),
        .o_result    (result),
        .o_marker    (marker)
    );

    sequence s_wake;
        I_WAKE;
    endsequence

    sequence s_fields_ones;
        ctrl == CTRL_RESET;
    endsequence

    sequence s_finish;
        done ##1 (state == ST_IDLE && !ctrl.go);
    endsequence

    a_wake_fields:
    assert property (@(posedge I_MCLK) disable iff (!I_RSTN) s_wake |=> s_fields_ones)
        else $error("wake did not restore control fields");

    a_sleep_fields:
    assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
        I_SLEEP && !I_WAKE |=> ctrl.conv_clock_select == CLK_SEL_RESET
        && ctrl.channel_select == CHAN_SEL_RESET && !ctrl.go && !ctrl.converter_enable
        && ctrl.analog_pin_select == $past(ctrl.analog_pin_select) && state == ST_IDLE)
        else $error("sleep entry left wrong control state");

    a_go_needs_enable:
    assert property (@(posedge I_MCLK) disable iff (!I_RSTN) ctrl.go |-> ctrl.converter_enable)
        else $error("go set while converter disabled");

    a_nine_shifts:
    assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
        s_finish |-> $past(shift_cnt) == SHIFT_TOTAL && marker == 8'h00)
        else $error("conversion ended without nine shifts");

    a_marker_last:
    assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
        shift_now && shift_cnt == SHIFT_TOTAL - 4'h1 |-> marker == MARKER_LAST)
        else $error("marker not at last bit before completion");

    a_clock_frozen:
    assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
        busy && !start ##1 busy |-> $stable(active_clk_sel))
        else $error("conversion clock changed mid conversion");

    a_channel_frozen:
    assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
        busy && !start && !abort && !done |=> $stable(O_CHANNEL))
        else $error("sampled channel changed mid conversion");

    a_result_held:
    assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
        state == ST_SAMPLE && !sample_end |=> $stable(result))
        else $error("result disturbed during sampling");

    a_result_cleared:
    assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
        sample_end && !abort |=> result == 8'h00 ##1 (result == 8'h00 || result == MARKER_TOP))
        else $error("result not cleared after sampling");

    a_abort_keeps:
    assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
        abort && !I_WAKE && !I_SLEEP |=> state == ST_IDLE && !ctrl.go
        && result == $past(result))
        else $error("abort did not stop with partial result");

    a_div4_spacing:
    assert property (@(posedge I_MCLK) disable iff (!I_RSTN || start)
        tad_tick && active_clk_sel == CLK_SEL_DIV4 |=> (!tad_tick)[*3] ##1 tad_tick)
        else $error("divide by four period wrong");

    a_pin_override:
    assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
        I_C1_OUT_EN |=> !O_ANALOG_PIN[2])
        else $error("comparator output did not take pin 2");

    a_power_follow:
    assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
        !ctrl.converter_enable |=> !O_CONVERTER_ON
        ##1 (!O_CONVERTING || $past(ctrl.converter_enable)))
        else $error("converter powered while disabled");

    a_all_analog:
    assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
        ctrl.analog_pin_select == PIN_SEL_RESET && !I_C1_OUT_EN |=> O_ANALOG_PIN == 3'b111)
        else $error("selected pins not forced analog");

    a_start_refused:
    assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
        wr_ctrl && !wdata.converter_enable |=> state == ST_IDLE)
        else $error("conversion running while disabled");

    a_done_clears_go:
    assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
        done && !wr_ctrl && !I_WAKE && !I_SLEEP |=> !ctrl.go && state == ST_IDLE)
        else $error("go not cleared at completion");

endmodule // adc_conversion_control

//--- logic/adc_pkg.sv
// Purpose: shared constants and types for the converter control block
// Assumes: one clock, wishbone register access with 32-bit data
// Notes:   control byte sits in the low bits of its word, upper bits read zero
package adc_pkg;

    // register byte addresses
    localparam logic [3:0] ADDR_CONTROL   = 4'h0;
    localparam logic [3:0] ADDR_RESULT    = 4'h4;

    // control byte field positions
    localparam int         POS_PIN_SEL    = 6;
    localparam int         POS_CLK_SEL    = 4;
    localparam int         POS_CHAN_SEL   = 2;
    localparam int         POS_GO         = 1;
    localparam int         POS_ENABLE     = 0;

    // reset / wake values (wake leaves the result alone; RESULT_RESET is loaded at reset only)
    localparam logic [1:0] PIN_SEL_RESET  = 2'h3;
    localparam logic [1:0] CLK_SEL_RESET  = 2'h3;
    localparam logic [1:0] CHAN_SEL_RESET = 2'h3;
    localparam logic [7:0] RESULT_RESET   = 8'h00;

    // clock select codes and divider terminal counts (divisor - 1)
    localparam logic [1:0] CLK_SEL_DIV16  = 2'h0;
    localparam logic [1:0] CLK_SEL_DIV8   = 2'h1;
    localparam logic [1:0] CLK_SEL_DIV4   = 2'h2;
    localparam logic [1:0] CLK_SEL_INTERNAL_OSCILLATOR = 2'h3;
    localparam logic [3:0] LAST_DIV16     = 4'hF;
    localparam logic [3:0] LAST_DIV8      = 4'h7;
    localparam logic [3:0] LAST_DIV4      = 4'h3;

    // analog pin select codes
    localparam logic [1:0] PINS_NONE      = 2'h0;
    localparam logic [1:0] PINS_IN2       = 2'h1;
    localparam logic [1:0] PINS_IN2_IN0   = 2'h2;

    // conversion timing in conversion-clock periods
    localparam logic [3:0] CONV_PERIODS   = 4'hD;
    localparam logic [3:0] SAMPLE_PERIODS = 4'h3;
    localparam logic [3:0] SHIFT_TOTAL    = 4'h9;
    localparam logic [7:0] MARKER_TOP     = 8'h80;
    localparam logic [7:0] MARKER_LAST    = 8'h01;

    typedef struct packed {
        logic [1:0] analog_pin_select;
        logic [1:0] conv_clock_select;
        logic [1:0] channel_select;
        logic       go;
        logic       converter_enable;
    } ctrl_t;

    localparam ctrl_t CTRL_RESET = '{PIN_SEL_RESET, CLK_SEL_RESET, CHAN_SEL_RESET, 1'b0, 1'b0};

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b001,
        ST_SAMPLE  = 3'b010,
        ST_CONVERT = 3'b100
    } conv_state_t;

endpackage

//--- logic/adc_result_shifter.sv
// Purpose: result register with a leading-one marker walking right
// Assumes: clear, shift and load are never asserted together
// Notes:   the marker leaves the register on the ninth shift
`timescale 1ns/10ps
module adc_result_shifter
    import adc_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_rstn,
    input  wire logic       i_clear,
    input  wire logic       i_shift,
    input  wire logic       i_bit,
    input  wire logic       i_load,
    input  wire logic [7:0] i_load_data,
    output logic      [7:0] o_result,
    output logic      [7:0] o_marker
);
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_result <= RESULT_RESET;
            o_marker <= 8'h00;
        end else if (i_clear) begin
            o_result <= 8'h00;
            o_marker <= 8'h00;
        end else if (i_shift && o_marker == 8'h00) begin
            o_result <= MARKER_TOP;
            o_marker <= MARKER_TOP;
        end else if (i_shift) begin
            // decided bit replaces the marker, marker moves one place down
            o_result <= (o_result & ~o_marker) | (i_bit ? o_marker : 8'h00) | (o_marker >> 1);
            o_marker <= o_marker >> 1;
        end else if (i_load) begin
            o_result <= i_load_data;
        end
    end
endmodule // adc_result_shifter
